// ---- pif_top.sv ----
module pif_top
  import pif_pkg::*;
#(
  parameter bit HAS_PARALLEL_PORT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [PIF_ADDR_W-1:0] addr_i,
  input wire logic [PIF_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [PIF_DATA_W-1:0] rdata_o,
  // peripheral events and levels
  input wire pif_evt_s evt_i,
  input wire logic serial_rx_full_i,
  input wire logic serial_tx_empty_i,
  input wire logic [7:0] usb_cause_status_i,
  input wire logic [7:0] usb_cause_enable_i,
  // reset cause pins from the reset logic
  input wire logic [PIF_PIN_COUNT-1:0] reset_cause_pins_i,
  // interrupt outputs
  output logic periph_irq_o,
  output logic global_irq_enable_o,
  output logic irq_o
);

  localparam logic [7:0] FLAGS1_IMPL = {HAS_PARALLEL_PORT, 7'h4f};
  // enables keep the serial bits too, so live serial levels can request
  localparam logic [7:0] ENABLES1_IMPL = {HAS_PARALLEL_PORT, 7'h7f};

  // register selects
  wire sel_core = (addr_i == PIF_ADDR_CORE_CTRL);
  wire sel_flags1 = (addr_i == PIF_ADDR_FLAGS_1);
  wire sel_flags2 = (addr_i == PIF_ADDR_FLAGS_2);
  wire sel_en1 = (addr_i == PIF_ADDR_ENABLES_1);
  wire sel_en2 = (addr_i == PIF_ADDR_ENABLES_2);
  wire sel_power_control_reg = (addr_i == PIF_ADDR_POWER_CTRL);
  wire sel_evt_st = (addr_i == PIF_ADDR_EVT_STATUS);
  wire sel_evt_mask = (addr_i == PIF_ADDR_EVT_MASK);
  wire wr_flags1 = wr_i & sel_flags1;
  wire wr_flags2 = wr_i & sel_flags2;
  wire wr_power_control_reg = wr_i & sel_power_control_reg;

  // usb summary: only enabled causes count
  wire usb_any = |(usb_cause_status_i & usb_cause_enable_i);

  // sticky set vector for the first flag register, ungated by the interrupt enable registers
  logic [7:0] flags1_set;
  assign flags1_set[PIF_BIT_PARALLEL] = evt_i.parallel_done & HAS_PARALLEL_PORT;
  assign flags1_set[PIF_BIT_ADC_DONE] = evt_i.adc_done;
  assign flags1_set[PIF_BIT_RX_FULL] = 1'b0;
  assign flags1_set[PIF_BIT_TX_EMPTY] = 1'b0;
  assign flags1_set[PIF_BIT_USB] = usb_any;
  assign flags1_set[PIF_BIT_CAPCOMP_ONE] = evt_i.capcomp_one;
  assign flags1_set[PIF_BIT_TIMER_TWO] = evt_i.timer_two_match;
  assign flags1_set[PIF_BIT_TIMER_ONE] = evt_i.timer_one_overflow;

  logic [7:0] flags1_sticky;
  logic [7:0] flags2_q;

  // sticky flags of the first bank; bits 5 and 4 are not stored here
  pif_flag_bank #(
    .WIDTH(8),
    .IMPL(FLAGS1_IMPL),
    .RST(PIF_RST_FLAGS)
  ) u_flags1 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(flags1_set),
    .wr_i(wr_flags1),
    .wdata_i(wdata_i),
    .q_o(flags1_sticky)
  );

  // second bank carries only the capcomp two flag
  pif_flag_bank #(
    .WIDTH(8),
    .IMPL(PIF_MASK_FLAGS_2),
    .RST(PIF_RST_FLAGS)
  ) u_flags2 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i({7'h00, evt_i.capcomp_two}),
    .wr_i(wr_flags2),
    .wdata_i(wdata_i),
    .q_o(flags2_q)
  );

  // serial bits are live levels owned by the serial unit, so no write can alter them
  logic [7:0] flags1_view;
  always_comb begin
    flags1_view = flags1_sticky;
    flags1_view[PIF_BIT_RX_FULL] = serial_rx_full_i;
    flags1_view[PIF_BIT_TX_EMPTY] = serial_tx_empty_i;
  end

  // reset cause pins come from another reset domain
  logic [PIF_PIN_COUNT-1:0] cause_lvl;
  logic [PIF_PIN_COUNT-1:0] cause_lvl_q;
  pif_pin_sync #(
    .WIDTH(PIF_PIN_COUNT)
  ) u_cause_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i(reset_cause_pins_i),
    .level_o(cause_lvl)
  );
  wire [PIF_PIN_COUNT-1:0] cause_rise = cause_lvl & ~cause_lvl_q;

  // enable, control and mask registers
  logic [7:0] en1_q;
  logic [7:0] en2_q;
  logic [7:0] core_q;
  logic [7:0] power_control_reg_q;
  logic [7:0] power_control_reg_d;
  logic [7:0] evt_st_q;
  logic [7:0] evt_st_d;
  logic [7:0] evt_mask_q;
  logic [7:0] evt_set;
  logic [PIF_DATA_W-1:0] rdata_q;
  logic [PIF_DATA_W-1:0] rdata_d;
  logic periph_irq_q;
  logic periph_irq_d;
  logic irq_q;

  // power control: brown-out clears, watchdog and pin set; hardware beats software
  always_comb begin
    power_control_reg_d = wr_power_control_reg ? (wdata_i & PIF_MASK_POWER_CTRL) : power_control_reg_q;
    if (cause_rise[PIF_PIN_BROWNOUT]) begin
      power_control_reg_d[PIF_BIT_BROWNOUT] = 1'b0;
    end
    if (cause_rise[PIF_PIN_WATCHDOG]) begin
      power_control_reg_d[PIF_BIT_WATCHDOG] = 1'b1;
    end
    if (cause_rise[PIF_PIN_EXT]) begin
      power_control_reg_d[PIF_BIT_EXT_PIN] = 1'b1;
    end
  end

  // request needs flag and matching enable, then the peripheral enable gate
  wire req1 = |(flags1_view & en1_q & ENABLES1_IMPL);
  wire req2 = |(flags2_q & en2_q & PIF_MASK_FLAGS_2);
  assign periph_irq_d = core_q[PIF_BIT_PERIPH_EN] & (req1 | req2);

  // block events: write one clears, a set in the same cycle wins
  assign evt_set = {6'h00, |cause_rise, periph_irq_d & ~periph_irq_q};
  assign evt_st_d = ((evt_st_q & ~((wr_i & sel_evt_st) ? wdata_i : 8'h00)) | evt_set)
                    & PIF_MASK_EVT;

  // read mux; unmapped addresses read zero, and the answer exists only after rd_i
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      if (sel_flags1) begin
        rdata_d = flags1_view;
      end else if (sel_flags2) begin
        rdata_d = flags2_q;
      end else if (sel_en1) begin
        rdata_d = en1_q;
      end else if (sel_en2) begin
        rdata_d = en2_q;
      end else if (sel_core) begin
        rdata_d = core_q;
      end else if (sel_power_control_reg) begin
        rdata_d = power_control_reg_q;
      end else if (sel_evt_st) begin
        rdata_d = evt_st_q;
      end else if (sel_evt_mask) begin
        rdata_d = evt_mask_q;
      end
    end
  end

  // software-owned registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en1_q <= PIF_RST_ENABLES;
      en2_q <= PIF_RST_ENABLES;
      core_q <= PIF_RST_CORE_CTRL;
      evt_mask_q <= PIF_RST_EVT;
    end else if (wr_i) begin
      if (sel_en1) begin
        en1_q <= wdata_i & ENABLES1_IMPL;
      end
      if (sel_en2) begin
        en2_q <= wdata_i & PIF_MASK_FLAGS_2;
      end
      if (sel_core) begin
        core_q <= wdata_i & PIF_MASK_CORE_CTRL;
      end
      if (sel_evt_mask) begin
        evt_mask_q <= wdata_i & PIF_MASK_EVT;
      end
    end
  end

  // hardware-updated state and registered outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_control_reg_q <= PIF_RST_POWER_CTRL;
      cause_lvl_q <= '0;
      evt_st_q <= PIF_RST_EVT;
      rdata_q <= 8'h00;
      periph_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      power_control_reg_q <= power_control_reg_d;
      cause_lvl_q <= cause_lvl;
      evt_st_q <= evt_st_d;
      rdata_q <= rdata_d;
      periph_irq_q <= periph_irq_d;
      irq_q <= |(evt_st_d & evt_mask_q);
    end
  end

  assign rdata_o = rdata_q;
  assign periph_irq_o = periph_irq_q;
  assign global_irq_enable_o = core_q[PIF_BIT_GLOBAL_EN];
  assign irq_o = irq_q;

endmodule

// ---- pif_pkg.sv ----
package pif_pkg;

  // register bus widths
  localparam int PIF_ADDR_W = 8;
  localparam int PIF_DATA_W = 8;

  // register offsets in data memory space
  localparam logic [7:0] PIF_ADDR_CORE_CTRL = 8'h0b;
  localparam logic [7:0] PIF_ADDR_FLAGS_1 = 8'h0c;
  localparam logic [7:0] PIF_ADDR_FLAGS_2 = 8'h0d;
  localparam logic [7:0] PIF_ADDR_ENABLES_1 = 8'h8c;
  localparam logic [7:0] PIF_ADDR_ENABLES_2 = 8'h8d;
  localparam logic [7:0] PIF_ADDR_POWER_CTRL = 8'h8e;
  localparam logic [7:0] PIF_ADDR_EVT_STATUS = 8'h90;
  localparam logic [7:0] PIF_ADDR_EVT_MASK = 8'h91;

  // peripheral_flags_1 / peripheral_enables_1 bit positions
  localparam int PIF_BIT_PARALLEL = 7;
  localparam int PIF_BIT_ADC_DONE = 6;
  localparam int PIF_BIT_RX_FULL = 5;
  localparam int PIF_BIT_TX_EMPTY = 4;
  localparam int PIF_BIT_USB = 3;
  localparam int PIF_BIT_CAPCOMP_ONE = 2;
  localparam int PIF_BIT_TIMER_TWO = 1;
  localparam int PIF_BIT_TIMER_ONE = 0;

  // peripheral_flags_2 / peripheral_enables_2 bit position
  localparam int PIF_BIT_CAPCOMP_TWO = 0;

  // core_irq_control bit positions
  localparam int PIF_BIT_GLOBAL_EN = 7;
  localparam int PIF_BIT_PERIPH_EN = 6;

  // power_control_reg bit positions
  localparam int PIF_BIT_BROWNOUT = 0;
  localparam int PIF_BIT_POWER_ON = 1;
  localparam int PIF_BIT_WATCHDOG = 2;
  localparam int PIF_BIT_EXT_PIN = 3;

  // event status / mask bit positions
  localparam int PIF_EVT_PERIPH_REQ = 0;
  localparam int PIF_EVT_RESET_CAUSE = 1;

  // reset cause pin indices
  localparam int PIF_PIN_BROWNOUT = 0;
  localparam int PIF_PIN_WATCHDOG = 1;
  localparam int PIF_PIN_EXT = 2;
  localparam int PIF_PIN_COUNT = 3;

  // values after reset
  localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIF_RST_ENABLES = 8'h00;
  localparam logic [7:0] PIF_RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] PIF_RST_POWER_CTRL = 8'h00;
  localparam logic [7:0] PIF_RST_EVT = 8'h00;

  // implemented bits of each register except the first flag and enable registers
  localparam logic [7:0] PIF_MASK_FLAGS_2 = 8'h01;
  localparam logic [7:0] PIF_MASK_CORE_CTRL = 8'hc0;
  localparam logic [7:0] PIF_MASK_POWER_CTRL = 8'h0f;
  localparam logic [7:0] PIF_MASK_EVT = 8'h03;

  // one-cycle event strobes from the on-chip peripherals
  typedef struct packed {
    logic parallel_done;
    logic adc_done;
    logic capcomp_one;
    logic timer_two_match;
    logic timer_one_overflow;
    logic capcomp_two;
  } pif_evt_s;

endpackage

// ---- pif_pin_sync.sv ----
module pif_pin_sync
  import pif_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // asynchronous pins and filtered levels
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;

  // three stages; only the second stage reads the first
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          level_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= pin_i[g];
          s2_q[g] <= meta_q[g];
          s3_q[g] <= s2_q[g];
          // a change counts only once stages two and three agree
          if (s2_q[g] == s3_q[g]) begin
            level_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  assign level_o = level_q;

endmodule

// ---- pif_flag_bank.sv ----
module pif_flag_bank
  import pif_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL = '1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // hardware set, software write
  input wire logic [WIDTH-1:0] set_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // stored flags
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] q_q;
  logic [WIDTH-1:0] q_d;

  // software may write either value; a hardware set in the same cycle wins
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign q_d[g] = IMPL[g] & ((wr_i ? wdata_i[g] : q_q[g]) | set_i[g]);
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          q_q[g] <= RST[g];
        end else begin
          q_q[g] <= q_d[g];
        end
      end
    end
  endgenerate

  assign q_o = q_q;

endmodule

// ---- pif_assertions.sv ----
module pif_assertions
  import pif_pkg::*;
#(
  parameter bit HAS_PARALLEL_PORT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [PIF_ADDR_W-1:0] addr_i,
  input wire logic [PIF_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [PIF_DATA_W-1:0] rdata_o,
  // peripheral side
  input wire pif_evt_s evt_i,
  input wire logic serial_rx_full_i,
  input wire logic serial_tx_empty_i,
  input wire logic [7:0] usb_cause_status_i,
  input wire logic [7:0] usb_cause_enable_i,
  input wire logic [PIF_PIN_COUNT-1:0] reset_cause_pins_i,
  // interrupt outputs
  input wire logic periph_irq_o,
  input wire logic global_irq_enable_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic pe_q;
  // shadow of the peripheral enable, so the gate can be judged without a read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) pe_q <= 1'b0;
    else if (wr_i && addr_i == PIF_ADDR_CORE_CTRL) pe_q <= wdata_i[PIF_BIT_PERIPH_EN];
  end
  // named reads of the two flag banks
  sequence rd_f1;
    rd_i && addr_i == PIF_ADDR_FLAGS_1;
  endsequence
  sequence rd_f2;
    rd_i && addr_i == PIF_ADDR_FLAGS_2;
  endsequence
  // an enabled usb cause is present
  sequence usb_cause;
    |(usb_cause_status_i & usb_cause_enable_i);
  endsequence
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  adc_set_a: assert property (evt_i.adc_done ##1 rd_f1 |=> rdata_o[6])
    else $error("conversion flag not set");
  rx_live_a: assert property (rd_f1 |=> rdata_o[5] == $past(serial_rx_full_i))
    else $error("receive flag not following buffer");
  tx_live_a: assert property (rd_f1 |=> rdata_o[4] == $past(serial_tx_empty_i))
    else $error("transmit flag not following buffer");
  usb_sum_a: assert property (usb_cause ##1 rd_f1 |=> rdata_o[3])
    else $error("usb summary flag not set");
  tmr1_set_a: assert property (evt_i.timer_one_overflow ##1 rd_f1 |=> rdata_o[0])
    else $error("timer one flag not set");
  cc2_set_a: assert property (evt_i.capcomp_two ##1 rd_f2 |=> rdata_o[0])
    else $error("capcomp two flag not set");
  par_zero_a: assert property (rd_f1 |=> HAS_PARALLEL_PORT || !rdata_o[7])
    else $error("parallel flag set without port");
  periph_gate_a: assert property (!pe_q && !$past(pe_q) |-> !periph_irq_o)
    else $error("peripheral request without enable");
endmodule
bind pif_top pif_assertions #(.HAS_PARALLEL_PORT(HAS_PARALLEL_PORT)) pif_assertions_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i),
  .serial_rx_full_i(serial_rx_full_i), .serial_tx_empty_i(serial_tx_empty_i),
  .usb_cause_status_i(usb_cause_status_i), .usb_cause_enable_i(usb_cause_enable_i),
  .reset_cause_pins_i(reset_cause_pins_i), .periph_irq_o(periph_irq_o),
  .global_irq_enable_o(global_irq_enable_o), .irq_o(irq_o));

// ---- pif_periph_model.sv ----
module pif_periph_model
  import pif_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // commands from the bench
  input wire pif_evt_s fire_i,
  input wire logic [1:0] serial_i,
  input wire logic [15:0] usb_i,
  input wire logic [2:0] pins_i,
  // peripheral outputs
  output pif_evt_s evt_o,
  output logic [1:0] serial_o,
  output logic [15:0] usb_o,
  output logic [2:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // peripherals launch everything from their own flops, one cycle after the command
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_o <= '0;
      serial_o <= 2'h0;
      usb_o <= 16'h0000;
      pins_o <= 3'h0;
    end else begin
      evt_o <= fire_i;
      serial_o <= serial_i;
      usb_o <= usb_i;
      pins_o <= pins_i;
    end
  end
endmodule

// ---- tb_peripheral_interrupt_flags.sv ----
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_peripheral_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ns;
  import pif_pkg::*;
  logic clk_sys_i, rst_n_i, wr, rd, pirq, global_irq_enable, irq;
  logic [7:0] addr, wdata, rdata, v, a;
  logic [1:0] ser;
  logic [15:0] usb, usb_m;
  logic [2:0] pins, pins_m;
  pif_evt_s fire, evt;
  logic [1:0] ser_m;
  int fails, checked, seed, k;
  // the clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  pif_periph_model pif_periph_model_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .fire_i(fire), .serial_i(ser), .usb_i(usb), .pins_i(pins), .evt_o(evt),
    .serial_o(ser_m), .usb_o(usb_m), .pins_o(pins_m));
  pif_top pif_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .evt_i(evt),
    .serial_rx_full_i(ser_m[1]), .serial_tx_empty_i(ser_m[0]),
    .usb_cause_status_i(usb_m[15:8]), .usb_cause_enable_i(usb_m[7:0]),
    .reset_cause_pins_i(pins_m), .periph_irq_o(pirq), .global_irq_enable_o(global_irq_enable),
    .irq_o(irq));
  // flag image expected in its bank for event index k
  function automatic logic [7:0] exp_of(input int k);
    case (k)
      5: return 8'h00;
      4: return 8'h40;
      3: return 8'h04;
      2: return 8'h02;
      default: return 8'h01;
    endcase
  endfunction
  task automatic complete_run();
    $display("mismatches %0d checks %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic ev(input logic [5:0] m);
    @(posedge clk_sys_i);
    fire <= pif_evt_s'(m);
    @(posedge clk_sys_i);
    fire <= '0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    fails++;
    complete_run();
  end
  initial begin
    {rst_n_i, wr, rd, addr, wdata, fire, ser, usb, pins} = '0;
    {fails, checked} = '0;
    seed = 93652;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_reg(PIF_ADDR_FLAGS_1, 8'h00);
    rd_reg(PIF_ADDR_FLAGS_2, 8'h00);
    rd_reg(PIF_ADDR_ENABLES_2, 8'h00);
    rd_reg(8'h55, 8'h00);
    // every event first, then random ones; enables stay clear throughout
    for (int n = 0; n < 16; n++) begin
      k = (n < 6) ? n : $unsigned($random(seed)) % 6;
      a = (k == 0) ? PIF_ADDR_FLAGS_2 : PIF_ADDR_FLAGS_1;
      ev(6'h01 << k);
      rd_reg(a, exp_of(k));
      wr_reg(a, 8'h00);
      rd_reg(a, 8'h00);
    end
    ser <= 2'h2;
    rd_reg(PIF_ADDR_FLAGS_1, 8'h20);
    wr_reg(PIF_ADDR_FLAGS_1, 8'h00);
    rd_reg(PIF_ADDR_FLAGS_1, 8'h20);
    ser <= 2'h1;
    rd_reg(PIF_ADDR_FLAGS_1, 8'h10);
    ser <= 2'h0;
    rd_reg(PIF_ADDR_FLAGS_1, 8'h00);
    v = $random(seed) | 8'h01;
    usb <= {v, ~v};
    tick(3);
    rd_reg(PIF_ADDR_FLAGS_1, 8'h00);
    usb <= {v, v};
    tick(3);
    rd_reg(PIF_ADDR_FLAGS_1, 8'h08);
    usb <= 16'h0000;
    v = $random(seed);
    wr_reg(PIF_ADDR_ENABLES_1, v);
    rd_reg(PIF_ADDR_ENABLES_1, v & 8'h7f);
    wr_reg(PIF_ADDR_ENABLES_2, 8'hff);
    rd_reg(PIF_ADDR_ENABLES_2, 8'h01);
    wr_reg(PIF_ADDR_FLAGS_1, 8'h00);
    wr_reg(PIF_ADDR_EVT_MASK, 8'h03);
    wr_reg(PIF_ADDR_ENABLES_1, 8'h40);
    wr_reg(PIF_ADDR_ENABLES_2, 8'h00);
    ev(6'h10);
    tick(3);
    `CHK("periph_irq", 1'b0, pirq)
    wr_reg(PIF_ADDR_CORE_CTRL, 8'hc0);
    tick(3);
    `CHK("periph_irq", 1'b1, pirq)
    `CHK("irq", 1'b1, irq)
    `CHK("global_en", 1'b1, global_irq_enable)
    wr_reg(PIF_ADDR_ENABLES_1, 8'h00);
    tick(3);
    `CHK("periph_irq", 1'b0, pirq)
    // a live serial level must request once its enable is set
    wr_reg(PIF_ADDR_ENABLES_1, 8'h10);
    ser <= 2'h1;
    tick(4);
    `CHK("periph_irq", 1'b1, pirq)
    ser <= 2'h0;
    tick(4);
    `CHK("periph_irq", 1'b0, pirq)
    wr_reg(PIF_ADDR_EVT_STATUS, 8'h01);
    tick(2);
    `CHK("irq", 1'b0, irq)
    // reset causes: the brown-out rise must clear the flag software set
    wr_reg(PIF_ADDR_POWER_CTRL, 8'h03);
    rd_reg(PIF_ADDR_POWER_CTRL, 8'h03);
    pins <= 3'h1;
    tick(8);
    rd_reg(PIF_ADDR_POWER_CTRL, 8'h02);
    `CHK("irq", 1'b1, irq)
    pins <= 3'h2;
    tick(8);
    rd_reg(PIF_ADDR_POWER_CTRL, 8'h06);
    pins <= 3'h4;
    tick(8);
    rd_reg(PIF_ADDR_POWER_CTRL, 8'h0e);
    complete_run();
  end
endmodule
